// File: verilog/wlf_pkg.sv
package wlf_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CMD_OFFSET    = 8'h88;
  localparam logic [7:0] STATUS_OFFSET = 8'hF0;
  localparam int         ADDR_WIDTH    = 8;

  // ****************************************************************
  // Command register fields
  // ****************************************************************
  localparam int COLD_WAKE_BIT    = 31;
  localparam int AUX_LSB          = 28;
  localparam int AUX_MSB          = 30;
  localparam int LED_QUAD_BIT     = 23;
  localparam int RX_FIFO_LSB      = 21;
  localparam int RX_FIFO_MSB      = 22;
  localparam int PM_ENABLE_BIT    = 19;
  localparam int LAN_WAKE_BIT     = 18;
  localparam int PTR_RESET_BIT    = 6;
  localparam int EEPROM_LSB       = 16;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int ST_ASLEEP_BIT    = 0;
  localparam int ST_AUX_BIT       = 1;
  localparam int ST_CAP_TOP_BIT   = 2;
  localparam int ST_LOADED_BIT    = 3;

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [2:0]  AUX_375MA        = 3'h7;
  localparam logic [2:0]  AUX_NONE         = 3'h0;
  localparam logic [1:0]  RX_FIFO_1K       = 2'h3;
  localparam logic [1:0]  RX_FIFO_2K       = 2'h2;
  localparam logic [1:0]  RX_FIFO_RESET    = 2'h2;
  localparam logic        COLD_WAKE_RESET  = 1'h0;
  localparam logic        LED_QUAD_RESET   = 1'h0;
  localparam logic        PM_ENABLE_RESET  = 1'h0;
  localparam logic        LAN_WAKE_RESET   = 1'h0;
  // Value returned by the capabilities pointer when power management is on
  localparam logic [7:0]  CAP_PTR_VALUE    = 8'h50;

  // ****************************************************************
  // Bus timing
  // ****************************************************************
  localparam int APB_WAIT_CYCLES = 1;

endpackage

// File: verilog/wlf_wake_filter.sv
`timescale 1ns/1ps
module wlf_wake_filter (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic soft_reset,
  // Mode
  input  wire logic pm_enable,
  input  wire logic lan_wake_mode,
  // Received frame classes, one-cycle pulses
  input  wire logic magic_frame,
  input  wire logic unicast_match,
  input  wire logic multicast_match,
  // Result
  output logic      wake_event
);

  logic accept_any;
  logic accept_special;

  // Lan wake mode narrows the accepted set to magic frames only
  assign accept_special = (pm_enable | lan_wake_mode) & magic_frame;
  assign accept_any     = pm_enable & ~lan_wake_mode & (unicast_match | multicast_match);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event <= 1'b0;
    end else if (soft_reset) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= accept_special | accept_any;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_lan_wake_special: assert property (@(posedge pclk) disable iff (!presetn)
    (lan_wake_mode && !magic_frame && !soft_reset) |=> !wake_event)
    else $error("wake raised in lan wake mode without special frame");

  a_pm_accepts_match: assert property (@(posedge pclk) disable iff (!presetn)
    (pm_enable && !lan_wake_mode && !soft_reset && (unicast_match || multicast_match)) |=> wake_event)
    else $error("matching frame ignored in power management mode");

endmodule

// File: verilog/wlf_command_reg.sv
`timescale 1ns/1ps
module wlf_command_reg (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        soft_reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // EEPROM image
  input  wire logic        eeprom_load,
  input  wire logic [15:0] eeprom_upper,
  // Power and frame events
  input  wire logic        aux_power_present,
  input  wire logic        magic_frame,
  input  wire logic        unicast_match,
  input  wire logic        multicast_match,
  // Link state for LEDs
  input  wire logic        link_up,
  input  wire logic        speed_100,
  input  wire logic        activity,
  input  wire logic        full_duplex,
  input  wire logic        collision,
  // Controls to the rest of the device
  output logic             pm_cap_top,
  output logic [7:0]       cap_ptr,
  output logic             pci_config_cmd_status_bit20,
  output logic [1:0]       rx_fifo_size,
  output logic             rx_fifo_2k,
  output logic             asleep,
  output logic             pattern_ptr_clear,
  output logic [3:0]       led
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic       cold_wake_support;
  logic [2:0] aux_current_load;
  logic       led_quad_select;
  logic [1:0] rx_fifo_code;
  logic       power_mgmt_enable;
  logic       lan_wake_sleep;
  logic       pattern_pointer_reset;
  logic       eeprom_loaded;
  logic       wake_event;

  logic       access;
  logic       cmd_hit;
  logic       status_hit;
  logic       cmd_write;
  logic       next_lan_wake;
  logic       wake_entry;
  logic [31:0] cmd_value;
  logic [31:0] status_value;

  // One wait state: pready rises in the second access cycle
  assign access     = psel & penable & pready;
  assign cmd_hit    = (paddr == wlf_pkg::CMD_OFFSET);
  assign status_hit = (paddr == wlf_pkg::STATUS_OFFSET);
  assign cmd_write  = access & pwrite & cmd_hit;

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      pslverr <= ~(cmd_hit | status_hit);
      if (pwrite) begin
        prdata <= 32'h0;
      end else if (cmd_hit) begin
        prdata <= cmd_value;
      end else if (status_hit) begin
        prdata <= status_value;
      end else begin
        prdata <= 32'h0;
      end
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Unlisted bits stay zero, so reserved positions read back as zero
  always_comb begin
    cmd_value = 32'h0;
    cmd_value[wlf_pkg::COLD_WAKE_BIT]                 = cold_wake_support;
    cmd_value[wlf_pkg::AUX_MSB:wlf_pkg::AUX_LSB]      = aux_current_load;
    cmd_value[wlf_pkg::LED_QUAD_BIT]                  = led_quad_select;
    cmd_value[wlf_pkg::RX_FIFO_MSB:wlf_pkg::RX_FIFO_LSB] = rx_fifo_code;
    cmd_value[wlf_pkg::PM_ENABLE_BIT]                 = power_mgmt_enable;
    cmd_value[wlf_pkg::LAN_WAKE_BIT]                  = lan_wake_sleep;
    cmd_value[wlf_pkg::PTR_RESET_BIT]                 = pattern_pointer_reset;
  end

  always_comb begin
    status_value = 32'h0;
    status_value[wlf_pkg::ST_ASLEEP_BIT]  = asleep;
    status_value[wlf_pkg::ST_AUX_BIT]     = aux_power_present;
    status_value[wlf_pkg::ST_CAP_TOP_BIT] = pm_cap_top;
    status_value[wlf_pkg::ST_LOADED_BIT]  = eeprom_loaded;
  end

  // ****************************************************************
  // Upper half: EEPROM image and software writes
  // ****************************************************************
  // A load and a write in one cycle: the EEPROM image wins, as it is a reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cold_wake_support <= wlf_pkg::COLD_WAKE_RESET;
      aux_current_load  <= wlf_pkg::AUX_NONE;
      led_quad_select   <= wlf_pkg::LED_QUAD_RESET;
      rx_fifo_code      <= wlf_pkg::RX_FIFO_RESET;
      power_mgmt_enable <= wlf_pkg::PM_ENABLE_RESET;
      eeprom_loaded     <= 1'b0;
    end else if (soft_reset) begin
      cold_wake_support <= wlf_pkg::COLD_WAKE_RESET;
      aux_current_load  <= wlf_pkg::AUX_NONE;
      led_quad_select   <= wlf_pkg::LED_QUAD_RESET;
      rx_fifo_code      <= wlf_pkg::RX_FIFO_RESET;
      power_mgmt_enable <= wlf_pkg::PM_ENABLE_RESET;
      eeprom_loaded     <= 1'b0;
    end else if (eeprom_load) begin
      cold_wake_support <= eeprom_upper[wlf_pkg::COLD_WAKE_BIT - wlf_pkg::EEPROM_LSB];
      aux_current_load  <= (eeprom_upper[wlf_pkg::COLD_WAKE_BIT - wlf_pkg::EEPROM_LSB] & aux_power_present)
                           ? wlf_pkg::AUX_375MA : wlf_pkg::AUX_NONE;
      led_quad_select   <= eeprom_upper[wlf_pkg::LED_QUAD_BIT - wlf_pkg::EEPROM_LSB];
      rx_fifo_code      <= eeprom_upper[wlf_pkg::RX_FIFO_MSB - wlf_pkg::EEPROM_LSB:
                                        wlf_pkg::RX_FIFO_LSB - wlf_pkg::EEPROM_LSB];
      power_mgmt_enable <= eeprom_upper[wlf_pkg::PM_ENABLE_BIT - wlf_pkg::EEPROM_LSB];
      eeprom_loaded     <= 1'b1;
    end else if (cmd_write) begin
      // Power management bit is read-only to software
      cold_wake_support <= pwdata[wlf_pkg::COLD_WAKE_BIT];
      aux_current_load  <= pwdata[wlf_pkg::AUX_MSB:wlf_pkg::AUX_LSB];
      led_quad_select   <= pwdata[wlf_pkg::LED_QUAD_BIT];
      rx_fifo_code      <= pwdata[wlf_pkg::RX_FIFO_MSB:wlf_pkg::RX_FIFO_LSB];
    end
  end

  // ****************************************************************
  // Sleep entry and exit
  // ****************************************************************
  always_comb begin
    next_lan_wake = lan_wake_sleep;
    if (eeprom_load) begin
      next_lan_wake = eeprom_upper[wlf_pkg::LAN_WAKE_BIT - wlf_pkg::EEPROM_LSB];
    end else if (cmd_write) begin
      next_lan_wake = pwdata[wlf_pkg::LAN_WAKE_BIT];
    end
  end

  assign wake_entry = next_lan_wake & ~lan_wake_sleep;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lan_wake_sleep <= wlf_pkg::LAN_WAKE_RESET;
    end else if (soft_reset) begin
      lan_wake_sleep <= wlf_pkg::LAN_WAKE_RESET;
    end else begin
      lan_wake_sleep <= next_lan_wake;
    end
  end

  // Entering sleep in the wake cycle wins, so a fresh request is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep <= 1'b0;
    end else if (soft_reset) begin
      asleep <= 1'b0;
    end else if (wake_entry) begin
      asleep <= 1'b1;
    end else if (!next_lan_wake || wake_event) begin
      asleep <= 1'b0;
    end
  end

  wlf_wake_filter u_wake_filter (
    .pclk            (pclk),
    .presetn         (presetn),
    .soft_reset      (soft_reset),
    .pm_enable       (power_mgmt_enable),
    .lan_wake_mode   (lan_wake_sleep),
    .magic_frame     (magic_frame),
    .unicast_match   (unicast_match),
    .multicast_match (multicast_match),
    .wake_event      (wake_event)
  );

  // ****************************************************************
  // Pattern pointer reset, self clearing
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_pointer_reset <= 1'b0;
      pattern_ptr_clear     <= 1'b0;
    end else begin
      pattern_pointer_reset <= cmd_write & pwdata[wlf_pkg::PTR_RESET_BIT];
      pattern_ptr_clear     <= cmd_write & pwdata[wlf_pkg::PTR_RESET_BIT];
    end
  end

  // ****************************************************************
  // Derived outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_cap_top                  <= 1'b0;
      cap_ptr                     <= 8'h00;
      pci_config_cmd_status_bit20 <= 1'b0;
      rx_fifo_size                <= wlf_pkg::RX_FIFO_RESET;
      rx_fifo_2k                  <= 1'b1;
    end else begin
      pm_cap_top                  <= cold_wake_support & aux_power_present;
      cap_ptr                     <= power_mgmt_enable ? wlf_pkg::CAP_PTR_VALUE : 8'h00;
      pci_config_cmd_status_bit20 <= power_mgmt_enable;
      rx_fifo_size                <= rx_fifo_code;
      // Reserved codes fall back to the larger size
      rx_fifo_2k                  <= (rx_fifo_code != wlf_pkg::RX_FIFO_1K);
    end
  end

  // LED map: quad mode splits link by speed and gives activity its own LED
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= 4'h0;
    end else if (led_quad_select) begin
      led <= {full_duplex | collision, activity, link_up & ~speed_100, link_up & speed_100};
    end else begin
      led <= {1'b0, full_duplex | collision, link_up & ~activity, speed_100};
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_lan_wake_write;
    cmd_write && pwdata[wlf_pkg::LAN_WAKE_BIT] && !lan_wake_sleep && !eeprom_load && !soft_reset;
  endsequence

  sequence s_sleeping;
    asleep && lan_wake_sleep;
  endsequence

  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_lan_wake_write |=> s_sleeping)
    else $error("lan wake write did not enter sleep");

  a_sleep_exit_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (asleep && cmd_write && !pwdata[wlf_pkg::LAN_WAKE_BIT] && !eeprom_load) |=> !asleep)
    else $error("clearing lan wake did not leave sleep");

  a_cap_top_gate: assert property (@(posedge pclk) disable iff (!presetn)
    pm_cap_top |-> $past(cold_wake_support) && $past(aux_power_present))
    else $error("capability top bit set without cold wake support");

  a_cap_ptr_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(power_mgmt_enable) |-> (cap_ptr == 8'h00) && !pci_config_cmd_status_bit20)
    else $error("capabilities pointer not zero with power management off");

  a_aux_default: assert property (@(posedge pclk) disable iff (!presetn)
    (eeprom_load && !soft_reset) |=> (aux_current_load == (cold_wake_support && $past(aux_power_present)
                                       ? wlf_pkg::AUX_375MA : wlf_pkg::AUX_NONE)))
    else $error("aux current default wrong after load");

  a_eeprom_reload: assert property (@(posedge pclk) disable iff (!presetn)
    (eeprom_load && !soft_reset) |=> (cmd_value[31:16] & 16'h80FF) == ($past(eeprom_upper) & 16'h80EC))
    else $error("EEPROM image not reloaded");

  a_ptr_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_write && pwdata[wlf_pkg::PTR_RESET_BIT]) |=> pattern_ptr_clear ##1 !pattern_pointer_reset)
    else $error("pointer reset pulse wrong");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && cmd_hit) |-> (prdata & 32'h0F13FFBF) == 32'h0)
    else $error("reserved bits read nonzero");

  a_fifo_select: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_fifo_code == wlf_pkg::RX_FIFO_1K) [*2] |-> !rx_fifo_2k)
    else $error("1K code did not select small FIFO");

  a_led_quad: assert property (@(posedge pclk) disable iff (!presetn)
    $past(led_quad_select) |-> led[2] == $past(activity))
    else $error("quad LED mode activity mismatch");

endmodule

// File: verification/wlf_eeprom_model.sv
`timescale 1ns/1ps
module wlf_eeprom_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request from the host side
  input  wire logic        load_req,
  input  wire logic [15:0] load_image,
  // Image towards the register block
  output logic             eeprom_load,
  output logic [15:0]      eeprom_upper
);
  // ********************
  // Image delivery
  // ********************
  // Idle image toggles every cycle so a stale value is never mistaken for a load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_load  <= 1'h0;
      eeprom_upper <= 16'hA5A5;
    end else if (load_req) begin
      eeprom_load  <= 1'h1;
      eeprom_upper <= load_image;
    end else begin
      eeprom_load  <= 1'h0;
      eeprom_upper <= ~eeprom_upper;
    end
  end
endmodule

// File: verification/wake_led_fifo_command_reg_bench.sv
`timescale 1ns/1ps
module wake_led_fifo_command_reg_bench;
  // ********************
  // Signals
  // ********************
  typedef struct packed {logic [31:0] wr; logic [31:0] rd; logic [3:0] led; logic cap;} wlf_row_type;
  logic        pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, cap_ptr;
  logic [31:0] pwdata, prdata, rd;
  logic        load_req, eeprom_load, aux_power_present, magic_frame, unicast_match, multicast_match;
  logic [15:0] load_image, eeprom_upper;
  logic        link_up, speed_100, activity, full_duplex, collision;
  logic        pm_cap_top, bit20, rx_fifo_2k, asleep, pattern_ptr_clear;
  logic [1:0]  rx_fifo_size;
  logic [3:0]  led;
  int          miscompares, n_compared, cycles, clears, wakes;
  wlf_row_type rows [0:3] = '{'{32'hFFFBFFBF, 32'hF0E00000, 4'h9, 1'h1}, '{32'h00000000, 32'h00000000, 4'h7, 1'h0},
                              '{32'h00400000, 32'h00400000, 4'h7, 1'h0}, '{32'h00A00000, 32'h00A00000, 4'h9, 1'h0}};

  wlf_command_reg dut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .eeprom_load(eeprom_load), .eeprom_upper(eeprom_upper), .aux_power_present(aux_power_present),
    .magic_frame(magic_frame), .unicast_match(unicast_match), .multicast_match(multicast_match),
    .link_up(link_up), .speed_100(speed_100), .activity(activity), .full_duplex(full_duplex),
    .collision(collision), .pm_cap_top(pm_cap_top), .cap_ptr(cap_ptr), .pci_config_cmd_status_bit20(bit20),
    .rx_fifo_size(rx_fifo_size), .rx_fifo_2k(rx_fifo_2k), .asleep(asleep),
    .pattern_ptr_clear(pattern_ptr_clear), .led(led));
  wlf_eeprom_model u_ee (.pclk(pclk), .presetn(presetn), .load_req(load_req), .load_image(load_image),
    .eeprom_load(eeprom_load), .eeprom_upper(eeprom_upper));

  initial pclk = 1'h0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (pattern_ptr_clear === 1'h1) clears++;
    if (dut.wake_event === 1'h1) wakes++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  // ********************
  // Tasks
  // ********************
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; waits on pready, then idles a fixed 3 cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Ends when pready is seen high; the 3000-cycle ceiling stops a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic eeload(input logic [15:0] img);
    load_req   <= 1'h1;
    load_image <= img;
    @(posedge pclk);
    load_req <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic frame(input int k);
    magic_frame     <= (k == 0);
    unicast_match   <= (k == 1);
    multicast_match <= (k == 2);
    @(posedge pclk);
    {magic_frame, unicast_match, multicast_match} <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    {presetn, soft_reset, psel, penable, pwrite, load_req, magic_frame, unicast_match, multicast_match} = 9'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    load_image = 16'h0;
    {link_up, speed_100, activity, full_duplex, collision, aux_power_present} = 6'h33;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(wlf_pkg::CMD_OFFSET, 32'h00400000);
    chk(32'(rx_fifo_2k), 32'h1);
    chk(32'(cap_ptr), 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, wlf_pkg::CMD_OFFSET, rows[i].wr);
      rdchk(wlf_pkg::CMD_OFFSET, rows[i].rd);
      chk(32'(rx_fifo_size), 32'(rows[i].rd[22:21]));
      chk(32'(rx_fifo_2k), 32'(rows[i].rd[22:21] != wlf_pkg::RX_FIFO_1K));
      chk(32'(led), 32'(rows[i].led));
      chk(32'(pm_cap_top), 32'(rows[i].cap));
    end
    $display("table test done");
    apb(1'h1, 8'h10, 32'hFFFFFFFF);
    chk(32'(err), 32'h1);
    apb(1'h0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, wlf_pkg::STATUS_OFFSET, 32'hFFFFFFFF);
    rdchk(wlf_pkg::CMD_OFFSET, 32'h00A00000);
    $display("refusal test done");
    aux_power_present <= 1'h0;
    eeload(16'h8000);
    rdchk(wlf_pkg::CMD_OFFSET, 32'h80000000);
    chk(32'(pm_cap_top), 32'h0);
    chk(32'(cap_ptr), 32'h0);
    chk(32'(bit20), 32'h0);
    aux_power_present <= 1'h1;
    eeload(16'hFFFF);
    rdchk(wlf_pkg::CMD_OFFSET, 32'hF0EC0000);
    chk(32'(pm_cap_top), 32'h1);
    chk(32'(cap_ptr), 32'(wlf_pkg::CAP_PTR_VALUE));
    chk(32'(bit20), 32'h1);
    chk(32'(asleep), 32'h1);
    rdchk(wlf_pkg::STATUS_OFFSET, 32'h0000000F);
    $display("load test done");
    frame(1);
    chk(32'(asleep), 32'h1);
    frame(2);
    chk(32'(asleep), 32'h1);
    frame(0);
    chk(32'(asleep), 32'h0);
    apb(1'h1, wlf_pkg::CMD_OFFSET, 32'h0);
    frame(1);
    frame(2);
    chk(32'(wakes), 32'h3);
    apb(1'h1, wlf_pkg::CMD_OFFSET, 32'h00040000);
    chk(32'(asleep), 32'h1);
    apb(1'h1, wlf_pkg::CMD_OFFSET, 32'h0);
    chk(32'(asleep), 32'h0);
    apb(1'h1, wlf_pkg::CMD_OFFSET, 32'h00040000);
    soft_reset <= 1'h1;
    @(posedge pclk);
    soft_reset <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(32'(asleep), 32'h0);
    rdchk(wlf_pkg::CMD_OFFSET, 32'h00400000);
    $display("sleep test done");
    apb(1'h1, wlf_pkg::CMD_OFFSET, 32'h00000040);
    chk(32'(clears), 32'h1);
    rdchk(wlf_pkg::CMD_OFFSET, 32'h0);
    apb(1'h1, wlf_pkg::CMD_OFFSET, 32'h00E00000);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(wlf_pkg::CMD_OFFSET, 32'h00400000);
    chk(32'(led), 32'h7);
    $display("pointer and reset test done");
    conclude();
  end
endmodule
